/* pkg/asd_defines.svh */
// Constants of the audio serial sample memory engine
`ifndef ASD_DEFINES_SVH
`define ASD_DEFINES_SVH
`define ASD_SW_8 2'h0
`define ASD_SW_16 2'h1
`define ASD_SW_24 2'h2
`define ASD_CH_STEREO 2'h0
`define ASD_CH_LEFT 2'h1
`define ASD_CH_RIGHT 2'h2
`define ASD_SLOT_LAST_8 2'h3
`define ASD_SLOT_LAST_16 2'h1
`define ASD_SLOT_LAST_24 2'h0
`define ASD_ZERO_FRAMES 2'h2
`define ASD_WORD_BYTES 32'h4
`define ASD_FIFO_WIDTH 32
`define ASD_FIFO_DEPTH 16
`define ASD_COUNT_WIDTH 14
`endif

/* pkg/asd_pkg.sv */
// Types of the audio serial sample memory engine
package asd_pkg;
   typedef struct packed
   {
      logic [23:0] left;
      logic [23:0] right;
   } asd_frame_s;
   typedef struct packed
   {
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } asd_memcmd_s;
   typedef enum logic {ST_IDLE, ST_RUN} asd_state_e;
endpackage

/* rtl/asd_dma.sv */
// Sample FIFO and memory engine of the serial audio interface
`timescale 1ns/1ps
`include "asd_defines.svh"
module asd_fifo #(parameter int W = `ASD_FIFO_WIDTH, parameter int D = `ASD_FIFO_DEPTH)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CLR,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [W-1:0] IN_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [W-1:0] OUT_DATA
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   wire push = IN_VALID && IN_READY;
   wire pop = OUT_VALID && OUT_READY;
   if (D < 2 || (1 << AW) != D)
   begin : g_chk
      $error("FIFO depth must be a power of two");
   end
   assign IN_READY = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
   assign OUT_VALID = wp_q != rp_q;
   assign OUT_DATA = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge CLK)
   begin
      if (RST || CLR)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
      end
   end
   always_ff @(posedge CLK)
   begin
      if (push)
         mem_q[wp_q[AW-1:0]] <= IN_DATA;
   end
endmodule

module asd_dma import asd_pkg::*; #(parameter int CW = `ASD_COUNT_WIDTH)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic START,
   input wire logic STOP,
   input wire logic TRANSMIT_ENABLE_CFG,
   input wire logic RECEIVE_ENABLE_CFG,
   input wire logic MASTER_CLOCK_GEN_ENABLE,
   input wire logic MASTER_MODE,
   input wire logic [1:0] SAMPLE_WIDTH_SELECT,
   input wire logic [1:0] CHANNEL_MODE,
   input wire logic [31:0] TX_BUFFER_START,
   input wire logic [31:0] RX_BUFFER_START,
   input wire logic [CW-1:0] SHARED_BUFFER_WORD_COUNT,
   output logic RUNNING,
   output logic MASTER_CLOCK_RUN,
   output logic TX_POINTER_TAKEN,
   output logic RX_POINTER_TAKEN,
   output logic STOPPED,
   output logic MEM_REQ,
   output asd_memcmd_s MEM_CMD,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_RDATA,
   output logic TX_FRAME_VALID,
   input wire logic TX_FRAME_READY,
   output asd_frame_s TX_FRAME,
   input wire logic RX_FRAME_VALID,
   input wire asd_frame_s RX_FRAME
);
   if (CW < 1 || CW > 32)
   begin : g_chk
      $error("Word count width out of range");
   end
   function automatic logic [1:0] last_slot(input logic [1:0] w);
      last_slot = (w == `ASD_SW_8) ? `ASD_SLOT_LAST_8 :
                  (w == `ASD_SW_16) ? `ASD_SLOT_LAST_16 : `ASD_SLOT_LAST_24;
   endfunction
   // Lower slots hold earlier samples, so stereo left sits below right
   function automatic logic [23:0] extract(input logic [31:0] d, input logic [1:0] s,
                                           input logic [1:0] w);
      logic [7:0] b;
      logic [15:0] h;
      b = d[{s, 3'h0} +: 8];
      h = d[{s[0], 4'h0} +: 16];
      extract = (w == `ASD_SW_8) ? {{16{b[7]}}, b} :
                (w == `ASD_SW_16) ? {{8{h[15]}}, h} : d[23:0];
   endfunction
   function automatic logic [31:0] insert(input logic [31:0] a, input logic [23:0] x,
                                          input logic [1:0] s, input logic [1:0] w);
      logic [31:0] r;
      r = a;
      if (w == `ASD_SW_8)
         r[{s, 3'h0} +: 8] = x[7:0];
      else if (w == `ASD_SW_16)
         r[{s[0], 4'h0} +: 16] = x[15:0];
      else
         r = {{8{x[23]}}, x};
      insert = r;
   endfunction

   asd_state_e state_q;
   logic mem_busy_q;
   logic [31:0] tx_addr_q, rx_addr_q;
   logic [CW-1:0] tx_left_q, rx_left_q;
   logic tx_taken_q, rx_taken_q, stopped_q, mck_q;
   logic tx_fv_q, tx_half_q;
   logic [1:0] tx_slot_q, zcnt_q;
   asd_frame_s tx_frm_q;
   logic [1:0] rx_n_q, rx_slot_q;
   logic [23:0] rx_s0_q, rx_s1_q;
   logic [31:0] acc_q, wbuf_q;
   logic wv_q;
   wire fifo_in_ready, fifo_ov;
   wire [31:0] fifo_od;

   wire running = state_q == ST_RUN;
   wire start_go = START && !running;
   wire stop_go = STOP && running;
   wire mono = CHANNEL_MODE != `ASD_CH_STEREO;
   wire [1:0] last = last_slot(SAMPLE_WIDTH_SELECT);
   wire tx_act = running && TRANSMIT_ENABLE_CFG;
   wire rx_act = running && RECEIVE_ENABLE_CFG;
   wire issue_wr = !mem_busy_q && wv_q && rx_act;
   wire issue_rd = !mem_busy_q && !issue_wr && tx_act && fifo_in_ready;
   wire ack_rd = mem_busy_q && MEM_ACK && !MEM_CMD.we;
   wire ack_wr = mem_busy_q && MEM_ACK && MEM_CMD.we;
   wire tx_wrap = ack_rd && tx_left_q == CW'(1);
   wire rx_wrap = ack_wr && rx_left_q == CW'(1);
   wire tx_free = !tx_fv_q || TX_FRAME_READY;
   wire tx_zero = tx_free && zcnt_q != 2'h0;
   wire tx_pop = tx_free && zcnt_q == 2'h0 && fifo_ov && tx_act;
   wire tx_pop_word = tx_pop && tx_slot_q == last;
   wire [23:0] tx_smp = extract(fifo_od, tx_slot_q, SAMPLE_WIDTH_SELECT);
   wire rx_done = rx_slot_q == last;
   wire rx_step = rx_n_q != 2'h0 && !(rx_done && wv_q && !ack_wr);
   wire [31:0] acc_new = insert(acc_q, rx_s0_q, rx_slot_q, SAMPLE_WIDTH_SELECT);

   asd_fifo #(.W(`ASD_FIFO_WIDTH), .D(`ASD_FIFO_DEPTH)) u_fifo
   (
      .CLK(CLK),
      .RST(RST),
      .CLR(start_go),
      .IN_VALID(ack_rd),
      .IN_READY(fifo_in_ready),
      .IN_DATA(MEM_RDATA),
      .OUT_VALID(fifo_ov),
      .OUT_READY(tx_pop_word),
      .OUT_DATA(fifo_od)
   );

   assign RUNNING = running;
   assign MASTER_CLOCK_RUN = mck_q;
   assign TX_POINTER_TAKEN = tx_taken_q;
   assign RX_POINTER_TAKEN = rx_taken_q;
   assign STOPPED = stopped_q;
   assign MEM_REQ = mem_busy_q;
   assign TX_FRAME_VALID = tx_fv_q;
   assign TX_FRAME = tx_frm_q;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_q <= ST_IDLE;
         mck_q <= 1'b0;
         stopped_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (start_go)
                  state_q <= ST_RUN;
            ST_RUN:
               if (stop_go)
                  state_q <= ST_IDLE;
         endcase
         mck_q <= start_go ? MASTER_CLOCK_GEN_ENABLE : (stop_go ? 1'b0 : mck_q);
         stopped_q <= stop_go;
      end
   end

   // A request stays up until acknowledged even if the direction is disabled meanwhile
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         mem_busy_q <= 1'b0;
         MEM_CMD <= '0;
      end
      else if (issue_wr || issue_rd)
      begin
         mem_busy_q <= 1'b1;
         MEM_CMD <= issue_wr ? '{1'b1, rx_addr_q, wbuf_q} : '{1'b0, tx_addr_q, 32'h0};
      end
      else if (MEM_ACK)
         mem_busy_q <= 1'b0;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         tx_addr_q <= '0;
         rx_addr_q <= '0;
         tx_left_q <= '0;
         rx_left_q <= '0;
         tx_taken_q <= 1'b0;
         rx_taken_q <= 1'b0;
      end
      else
      begin
         if (start_go || tx_wrap)
         begin
            tx_addr_q <= TX_BUFFER_START;
            tx_left_q <= SHARED_BUFFER_WORD_COUNT;
         end
         else if (ack_rd)
         begin
            tx_addr_q <= tx_addr_q + `ASD_WORD_BYTES;
            tx_left_q <= tx_left_q - 1'b1;
         end
         if (start_go || rx_wrap)
         begin
            rx_addr_q <= RX_BUFFER_START;
            rx_left_q <= SHARED_BUFFER_WORD_COUNT;
         end
         else if (ack_wr)
         begin
            rx_addr_q <= rx_addr_q + `ASD_WORD_BYTES;
            rx_left_q <= rx_left_q - 1'b1;
         end
         tx_taken_q <= (start_go && TRANSMIT_ENABLE_CFG) || tx_wrap;
         rx_taken_q <= (start_go && RECEIVE_ENABLE_CFG) || rx_wrap;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST || start_go)
      begin
         tx_fv_q <= 1'b0;
         tx_half_q <= 1'b0;
         tx_slot_q <= 2'h0;
         tx_frm_q <= '0;
         zcnt_q <= (!RST && MASTER_MODE && TRANSMIT_ENABLE_CFG) ? `ASD_ZERO_FRAMES : 2'h0;
      end
      else
      begin
         if (tx_zero)
         begin
            tx_frm_q <= '0;
            zcnt_q <= zcnt_q - 1'b1;
         end
         else if (tx_pop && (mono || !tx_half_q))
            tx_frm_q.left <= tx_smp;
         if (tx_pop && (mono || tx_half_q))
            tx_frm_q.right <= tx_smp;
         if (tx_zero || (tx_pop && (mono || tx_half_q)))
            tx_fv_q <= 1'b1;
         else if (TX_FRAME_READY)
            tx_fv_q <= 1'b0;
         if (tx_pop)
         begin
            tx_half_q <= !mono && !tx_half_q;
            tx_slot_q <= (tx_slot_q == last) ? 2'h0 : tx_slot_q + 1'b1;
         end
      end
   end

   // Audio cannot wait: a frame arriving before the previous one is packed overwrites it
   always_ff @(posedge CLK)
   begin
      if (RST || start_go)
      begin
         rx_n_q <= 2'h0;
         rx_s0_q <= '0;
         rx_s1_q <= '0;
         rx_slot_q <= 2'h0;
         acc_q <= '0;
         wbuf_q <= '0;
         wv_q <= 1'b0;
      end
      else
      begin
         if (RX_FRAME_VALID && rx_act)
         begin
            rx_n_q <= mono ? 2'h1 : 2'h2;
            rx_s0_q <= (CHANNEL_MODE == `ASD_CH_RIGHT) ? RX_FRAME.right : RX_FRAME.left;
            rx_s1_q <= RX_FRAME.right;
         end
         else if (rx_step)
         begin
            rx_n_q <= rx_n_q - 1'b1;
            rx_s0_q <= rx_s1_q;
         end
         if (rx_step)
         begin
            rx_slot_q <= rx_done ? 2'h0 : rx_slot_q + 1'b1;
            acc_q <= rx_done ? 32'h0 : acc_new;
         end
         if (rx_step && rx_done)
         begin
            wbuf_q <= acc_new;
            wv_q <= 1'b1;
         end
         else if (ack_wr)
            wv_q <= 1'b0;
      end
   end

   sequence s_stop_req;
      STOP && RUNNING;
   endsequence
   chk_tx_read_gate: assert property (@(posedge CLK) disable iff (RST)
      $rose(MEM_REQ) && !MEM_CMD.we |-> $past(TRANSMIT_ENABLE_CFG) && $past(RUNNING))
      else $error("read while transmit off");
   chk_rx_write_gate: assert property (@(posedge CLK) disable iff (RST)
      $rose(MEM_REQ) && MEM_CMD.we |-> $past(RECEIVE_ENABLE_CFG) && $past(RUNNING))
      else $error("write while receive off");
   chk_tx_shadow_reload: assert property (@(posedge CLK) disable iff (RST)
      tx_wrap && !start_go |=> tx_addr_q == $past(TX_BUFFER_START) && TX_POINTER_TAKEN)
      else $error("transmit shadow not reloaded");
   chk_rx_taken_event: assert property (@(posedge CLK) disable iff (RST)
      rx_wrap |=> RX_POINTER_TAKEN && rx_left_q == $past(SHARED_BUFFER_WORD_COUNT))
      else $error("receive pointer event missing");
   chk_tx_addr_step: assert property (@(posedge CLK) disable iff (RST)
      ack_rd && !tx_wrap && !start_go |=> tx_addr_q == $past(tx_addr_q) + `ASD_WORD_BYTES)
      else $error("transmit address step wrong");
   chk_rx_sign_fill: assert property (@(posedge CLK) disable iff (RST)
      issue_wr && SAMPLE_WIDTH_SELECT == `ASD_SW_24
      |=> MEM_CMD.wdata[31:24] == {8{MEM_CMD.wdata[23]}})
      else $error("24-bit word not sign extended");
   chk_mono_both: assert property (@(posedge CLK) disable iff (RST)
      TX_FRAME_VALID && mono && $stable(CHANNEL_MODE) && zcnt_q == 2'h0 && $past(tx_pop)
      |-> TX_FRAME.left == TX_FRAME.right) else $error("mono halves differ");
   chk_start_clock: assert property (@(posedge CLK) disable iff (RST)
      start_go |=> RUNNING && MASTER_CLOCK_RUN == $past(MASTER_CLOCK_GEN_ENABLE))
      else $error("start did not run");
   chk_stop_event: assert property (@(posedge CLK) disable iff (RST)
      s_stop_req |=> STOPPED && !RUNNING && !MASTER_CLOCK_RUN ##1 !STOPPED)
      else $error("stop event wrong");
   chk_zero_first: assert property (@(posedge CLK) disable iff (RST)
      start_go && MASTER_MODE && TRANSMIT_ENABLE_CFG |=> zcnt_q == `ASD_ZERO_FRAMES && !tx_pop)
      else $error("zero frames not armed");
endmodule

/* sim/asd_mem_model.sv */
// Data RAM partner that answers the memory requests of the engine
`timescale 1ns/1ps
module asd_mem_model import asd_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic SLOW,
   input wire logic MEM_REQ,
   input wire asd_memcmd_s MEM_CMD,
   output logic MEM_ACK,
   output logic [31:0] MEM_RDATA
);
   logic [31:0] mem [64];
   logic [1:0] wait_q;
   logic done_q;
   // Only the low address bits decode, so pointers must stay inside this RAM
   wire [5:0] idx = MEM_CMD.addr[7:2];
   wire hit = MEM_REQ && !done_q && (wait_q == (SLOW ? 2'h3 : 2'h0));
   // Read data is only valid with the ack; otherwise it toggles every cycle
   always @(posedge CLK)
   begin
      if (RST)
      begin
         MEM_ACK <= 1'b0;
         done_q <= 1'b0;
         wait_q <= 2'h0;
         MEM_RDATA <= 32'h0;
      end
      else
      begin
         MEM_ACK <= hit;
         done_q <= MEM_REQ && (done_q || hit);
         wait_q <= (MEM_REQ && !hit && !done_q) ? wait_q + 2'h1 : 2'h0;
         MEM_RDATA <= (hit && !MEM_CMD.we) ? mem[idx] : ~MEM_RDATA;
         if (hit && MEM_CMD.we)
            mem[idx] <= MEM_CMD.wdata;
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench of the audio serial sample memory engine
`timescale 1ns/1ps
`include "asd_defines.svh"
module testbench import asd_pkg::*;;
   localparam int CNT = 2;
   // Rows: width, channel mode, master mode
   localparam logic [4:0] ROWS [6] = '{5'h00, 5'h02, 5'h08, 5'h0D, 5'h10, 5'h13};
   logic clk, rst, start, stop, txe, rxe, mcke, mm, slow, trdy, rxv;
   logic [1:0] sw, ch;
   logic [31:0] txb, rxb, rdata;
   logic run, mrun, txp, rxp, stp, req, ack, tv;
   asd_memcmd_s cmd;
   asd_frame_s tf, rf;
   logic [31:0] img [CNT] = '{32'hC3817E05, 32'h5AF00FA5};
   logic [63:0] wq [$];
   asd_frame_s fq [$];
   int n_fail = 0, check_count = 0, rd_n, txp_n, rxp_n, k;
   asd_dma asd_dma_i (.CLK(clk), .RST(rst), .START(start), .STOP(stop),
      .TRANSMIT_ENABLE_CFG(txe), .RECEIVE_ENABLE_CFG(rxe), .MASTER_CLOCK_GEN_ENABLE(mcke),
      .MASTER_MODE(mm), .SAMPLE_WIDTH_SELECT(sw), .CHANNEL_MODE(ch), .TX_BUFFER_START(txb),
      .RX_BUFFER_START(rxb), .SHARED_BUFFER_WORD_COUNT(14'(CNT)), .RUNNING(run),
      .MASTER_CLOCK_RUN(mrun), .TX_POINTER_TAKEN(txp), .RX_POINTER_TAKEN(rxp),
      .STOPPED(stp), .MEM_REQ(req), .MEM_CMD(cmd), .MEM_ACK(ack), .MEM_RDATA(rdata),
      .TX_FRAME_VALID(tv), .TX_FRAME_READY(trdy), .TX_FRAME(tf), .RX_FRAME_VALID(rxv),
      .RX_FRAME(rf));
   asd_mem_model asd_mem_model_i (.CLK(clk), .RST(rst), .SLOW(slow), .MEM_REQ(req),
      .MEM_CMD(cmd), .MEM_ACK(ack), .MEM_RDATA(rdata));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic p);
      p = 1;
      tick(1);
      p = 0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Sample k of the transmit image, sign-extended to the frame width
   function automatic logic [23:0] smp(int k);
      logic [31:0] w;
      int per;
      per = (sw == `ASD_SW_8) ? 4 : (sw == `ASD_SW_16) ? 2 : 1;
      w = img[(k / per) % CNT] >> (32 / per * (k % per));
      case (sw)
         `ASD_SW_8: return {{16{w[7]}}, w[7:0]};
         `ASD_SW_16: return {{8{w[15]}}, w[15:0]};
         default: return w[23:0];
      endcase
   endfunction
   function automatic asd_frame_s exp_frame(int f);
      int j;
      j = f - 2 * int'(mm);
      if (j < 0)
         return '0;
      if (ch == `ASD_CH_STEREO)
         return {smp(2 * j), smp(2 * j + 1)};
      return {smp(j), smp(j)};
   endfunction
   // Send receive frames; writes expected in wq, pointer pulses expected p
   task automatic rx_go(input asd_frame_s fr[$], input int p);
      rxp_n = 0;
      pulse(start);
      foreach (fr[i])
      begin
         rf = fr[i];
         rxv = 1;
         tick(1);
         rxv = 0;
         tick(10);
      end
      tick(20);
      pulse(stop);
      cmp(rxp_n, p);
      cmp(wq.size(), 0);
   endtask
   always @(posedge clk)
   begin
      txp_n += txp;
      rxp_n += rxp;
      if (tv && trdy)
         fq.push_back(tf);
      if (req && ack && !cmd.we)
      begin
         cmp(txe, 1);
         cmp(cmd.addr, txb + 32'(4 * (rd_n % CNT)));
         rd_n++;
      end
      if (req && ack && cmd.we)
      begin
         cmp(rxe, 1);
         cmp({cmd.addr, cmd.wdata}, wq.size() > 0 ? wq.pop_front() : '1);
      end
   end
   initial
   begin
      {start, stop, txe, rxe, mcke, mm, slow, trdy, rxv, sw, ch, rf} = '0;
      txb = 32'h20;
      rxb = 32'h80;
      rst = 1;
      tick(10);
      cmp({run, mrun, txp, rxp, stp, req, tv, cmd.we, cmd.addr}, 0);
      rst = 0;
      foreach (img[i])
         asd_mem_model_i.mem[8 + i] = img[i];
      foreach (ROWS[r])
      begin
         {sw, ch, mm} = ROWS[r];
         mcke = r[0];
         slow = r[1];
         txe = 1;
         trdy = 0;
         rd_n = 0;
         txp_n = 0;
         fq = {};
         pulse(start);
         cmp({run, mrun}, {1'b1, mcke});
         tick(200);
         k = rd_n;
         tick(50);
         // A full FIFO must hold off further reads while frames stall
         cmp(rd_n, k);
         cmp(fq.size(), 0);
         trdy = 1;
         tick(60);
         cmp(fq.size() > 5, 1);
         for (int f = 0; f < 6; f++)
            cmp(fq[f], exp_frame(f));
         trdy = 0;
         tick(100);
         pulse(stop);
         cmp({stp, run, mrun}, 3'b100);
         tick(10);
         cmp(txp_n, 1 + rd_n / CNT);
      end
      txe = 0;
      rxe = 1;
      sw = `ASD_SW_24;
      ch = `ASD_CH_STEREO;
      wq = '{{rxb, 32'hFF800001}, {rxb + 32'h4, 32'h007FFFFE}};
      rx_go('{48'h8000017FFFFE}, 2);
      sw = `ASD_SW_16;
      wq = '{{rxb, 32'hBEEF8001}, {rxb + 32'h4, 32'h56781234}};
      rx_go('{48'h008001FFBEEF, 48'h001234005678}, 2);
      sw = `ASD_SW_8;
      ch = `ASD_CH_RIGHT;
      wq = '{{rxb, 32'h44832211}};
      rx_go('{48'hAA11, 48'hBB22, 48'hCC83, 48'hDD44}, 1);
      sw = `ASD_SW_24;
      ch = `ASD_CH_LEFT;
      wq = '{{rxb, 32'h00123456}, {rxb + 32'h4, 32'hFFFEDCBA}};
      rx_go('{48'h123456ABCDEF, 48'hFEDCBA000111}, 2);
      // Awkward cases: a repeated start, a reset while running, a stop while idle
      pulse(start);
      cmp(rxp, 1);
      tick(1);
      pulse(start);
      cmp({run, rxp}, 2'b10);
      rst = 1;
      tick(1);
      cmp({run, mrun, txp, rxp, stp, req, tv, cmd.we, cmd.addr}, 0);
      rst = 0;
      pulse(stop);
      cmp({stp, run}, 2'b00);
      pulse(start);
      cmp({run, mrun, rxp}, 3'b111);
      pulse(stop);
      cmp({stp, run, mrun}, 3'b100);
      close_out();
   end
   initial
   begin
      #200000;
      n_fail++;
      close_out();
   end
endmodule
